// File: hdl/rcs_pkg.sv
/*
  Constants, register map and types of the receiver lock and status block.
  Assumes a 200 MHz system clock and a classic Wishbone register bus.
*/
// Function
// R1 - fifo error high when full or empty
// R2 - optional read clock for phase fifo
// R3 - manual aligner slip count, 0 to 9
// R4 - lock indicator high locked-to-data, low reference
// R5 - lock-to-data high forces data lock
// R6 - lock-to-data low: reference control decides
// R7 - control pair 00 auto, 01 ref, 1x data
// R8 - signal detect high above threshold
// R9 - signal detect only basic-8b10b or pipe
// R10 - recovered clock only in gigabit ethernet mode
// R11 - pipe without inference: idle is inverted detect
// R12 - lock controls pass two flip-flops first
`default_nettype none
package rcs_pkg;
  // bus geometry
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          LVL_W           = 8;
  localparam int          AMP_W           = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] REG_THRESH    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SLIP      = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK  = 8'h14;

  // control register fields
  localparam int          CTRL_MODE_LSB   = 0;
  localparam int          CTRL_MANUAL_BIT = 2;
  localparam int          CTRL_RDCLK_BIT  = 3;
  localparam int          CTRL_INFER_BIT  = 4;
  localparam int          CTRL_W          = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [AMP_W-1:0]  THRESH_RESET = 8'h40;

  // status register fields
  localparam int          ST_LOCK_BIT     = 0;
  localparam int          ST_SIGDET_BIT   = 1;
  localparam int          ST_FIFOERR_BIT  = 2;
  localparam int          ST_EIDLE_BIT    = 3;
  localparam int          ST_MODE_LSB     = 4;
  localparam int          ST_SLIP_LSB     = 8;

  // interrupt bits
  localparam int          IRQ_W           = 3;
  localparam int          IRQ_LOCK_BIT    = 0;
  localparam int          IRQ_FIFO_BIT    = 1;
  localparam int          IRQ_SIGDET_BIT  = 2;

  // slip counter
  localparam int          SLIP_W          = 4;
  localparam logic [SLIP_W-1:0] SLIP_LAST = 4'h9;

  // phase compensation fifo depth (full level)
  localparam logic [LVL_W-1:0]  FIFO_FULL_LVL = 8'h08;
  localparam logic [LVL_W-1:0]  FIFO_EMPTY_LVL = 8'h00;

  // timing
  localparam int          CLK_MHZ         = 200;
  localparam int          LOCK_HOLD_NS    = 1000;
  localparam int          LOCK_HOLD_CYC   = (LOCK_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int          HOLD_W          = 10;
  localparam int          DIV_W           = 4;
  localparam logic [DIV_W-1:0] RDCLK_HALF = 4'h1;
  localparam logic [DIV_W-1:0] RECCLK_HALF = 4'h3;

  // channel modes
  typedef enum logic [1:0] {
    MODE_BASIC    = 2'b00,
    MODE_BASIC_8B = 2'b01,
    MODE_PIPE     = 2'b10,
    MODE_GIGABIT_ETHERNET = 2'b11
  } rcs_mode_e;

  // clock recovery lock states
  typedef enum logic [1:0] {
    CDR_REF_AUTO = 2'b00,
    CDR_DATA_AUTO = 2'b01,
    CDR_REF_MAN  = 2'b10,
    CDR_DATA_MAN = 2'b11
  } rcs_cdr_e;
endpackage
`default_nettype wire

// File: hdl/rcs_sync.sv
/*
  Two flip-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level; bits are not kept coherent.
*/
`timescale 1ns/1ps
`default_nettype none
module rcs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: hdl/rcs_top.sv
/*
  Receiver clock recovery lock control and channel status, with a
  Wishbone register file and a masked level interrupt.
  Assumes pins arrive asynchronous to clk_i; fifo level comes from
  logic on clk_i. Lock pins are synchronised bit by bit, so a change
  of both may pass one cycle of an in-between code; harmless, as the
  lock state only settles once the pair is stable.
*/
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rcs_top (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [rcs_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [rcs_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [rcs_pkg::DATA_W-1:0] wb_dat_o,
  output logic                            wb_ack_o,
  output logic                            irq_o,
  // asynchronous lock controls and line status pins
  input  wire logic                       lock_to_data_i,
  input  wire logic                       lock_to_ref_i,
  input  wire logic                       freq_ok_i,
  input  wire logic [rcs_pkg::AMP_W-1:0]  line_amp_i,
  input  wire logic                       eidle_inferred_i,
  input  wire logic                       slip_req_i,
  // phase fifo level, same clock
  input  wire logic [rcs_pkg::LVL_W-1:0]  fifo_level_i,
  // status outputs
  output logic                            locked_to_data_o,
  output logic                            sig_detect_o,
  output logic                            elec_idle_o,
  output logic                            fifo_error_o,
  output logic      [rcs_pkg::SLIP_W-1:0] aligner_slip_count_o,
  output logic                            fifo_read_clk_o,
  output logic                            recov_clk_o
);
  import rcs_pkg::*;

  // synchronised pins
  logic [AMP_W+5-1:0] pins_async;
  logic [AMP_W+5-1:0] pins_sync;
  logic               ltd_s;
  logic               ref_ctl_s;
  logic               freq_ok_s;
  logic               infer_s;
  logic               slip_s;
  logic [AMP_W-1:0]   amp_s;

  assign pins_async = {line_amp_i, slip_req_i, eidle_inferred_i, freq_ok_i, lock_to_ref_i, lock_to_data_i};

  // lock controls and line levels pass two stages first
  rcs_sync #(.W(AMP_W+5)) u_sync ( // [R12]
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (pins_async),
    .sync_o  (pins_sync)
  );

  // unpack in the order packed above
  assign ltd_s     = pins_sync[0];
  assign ref_ctl_s = pins_sync[1];
  assign freq_ok_s = pins_sync[2];
  assign infer_s   = pins_sync[3];
  assign slip_s    = pins_sync[4];
  assign amp_s     = pins_sync[AMP_W+5-1:5];

  // registers
  logic [CTRL_W-1:0]  ctrl_q;
  logic [AMP_W-1:0]   thresh_q;
  logic [IRQ_W-1:0]   irq_stat_q;
  logic [IRQ_W-1:0]   irq_stat_d;
  logic [IRQ_W-1:0]   irq_mask_q;
  rcs_cdr_e           cdr_q;
  rcs_cdr_e           cdr_d;
  logic [HOLD_W-1:0]  hold_q;
  logic [SLIP_W-1:0]  slip_q;
  logic               slip_prev_q;
  logic [DIV_W-1:0]   rd_div_q;
  logic [DIV_W-1:0]   rec_div_q;

  // bus decode
  wire                bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire                bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
  wire                wr_ctrl   = bus_wr & (wb_adr_i == REG_CTRL);
  wire                wr_thresh = bus_wr & (wb_adr_i == REG_THRESH);
  wire                wr_slip   = bus_wr & (wb_adr_i == REG_SLIP);
  wire                wr_mask   = bus_wr & (wb_adr_i == REG_IRQ_MASK);
  wire                rd_istat  = bus_req & ~wb_we_i & (wb_adr_i == REG_IRQ_STAT);

  // configuration fields
  rcs_mode_e          mode;
  assign mode = rcs_mode_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
  wire                manual_align = ctrl_q[CTRL_MANUAL_BIT];
  wire                rdclk_en     = ctrl_q[CTRL_RDCLK_BIT];
  wire                infer_en     = ctrl_q[CTRL_INFER_BIT];
  wire                is_pipe      = (mode == MODE_PIPE);
  wire                gigabit_ethernet_mode = (mode == MODE_GIGABIT_ETHERNET);
  wire                sigdet_avail = (mode == MODE_BASIC_8B) | is_pipe;

  // lock control pair: 00 auto, 01 ref, 1x data
  wire [1:0]          lock_ctl     = {ltd_s, ref_ctl_s}; // [R7]
  wire                force_data   = lock_ctl[1];                   // [R5]
  wire                force_ref    = (lock_ctl == 2'b01);           // [R6]
  wire                hold_done    = (hold_q == HOLD_W'(LOCK_HOLD_CYC - 1));

  // next lock state
  always_comb begin
    cdr_d = cdr_q;
    if (force_data) begin
      cdr_d = CDR_DATA_MAN; // [R5]
    end else if (force_ref) begin
      cdr_d = CDR_REF_MAN; // [R6]
    end else begin
      // automatic: move to data once frequency holds long enough
      case (cdr_q)
        CDR_REF_AUTO: begin
          if (freq_ok_s && hold_done) begin
            cdr_d = CDR_DATA_AUTO;
          end
        end
        CDR_DATA_AUTO: begin
          if (!freq_ok_s) begin
            cdr_d = CDR_REF_AUTO;
          end
        end
        default: cdr_d = CDR_REF_AUTO; // leaving manual restarts acquisition
      endcase
    end
  end

  // taken from the next state so the output flop lands together with cdr_q
  wire                locked_data  = (cdr_d == CDR_DATA_AUTO) | (cdr_d == CDR_DATA_MAN);

  // lock state and frequency hold counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cdr_q  <= CDR_REF_AUTO;
      hold_q <= '0;
    end else begin
      cdr_q  <= cdr_d;
      if (cdr_q == CDR_REF_AUTO && freq_ok_s && !hold_done) begin
        hold_q <= hold_q + 1'b1; // frequency still has to prove stable
      end else begin
        hold_q <= '0; // any dropout restarts the wait
      end
    end
  end

  // status derivation
  wire                sigdet_d     = sigdet_avail & (amp_s > thresh_q); // [R8] [R9]
  wire                eidle_d      = is_pipe & (infer_en ? infer_s : ~sigdet_d); // [R11]
  wire                fifo_err_d   = (fifo_level_i >= FIFO_FULL_LVL) |
                                     (fifo_level_i == FIFO_EMPTY_LVL); // [R1]
  wire                slip_edge    = slip_s & ~slip_prev_q;
  wire                slip_step    = manual_align & (slip_edge | wr_slip);
  wire [SLIP_W-1:0]   slip_next    = (slip_q == SLIP_LAST) ? '0 : slip_q + 1'b1; // [R3]

  // word aligner slip count, wraps after nine
  // a pin edge and a write in one cycle give a single slip
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slip_q      <= '0;
      slip_prev_q <= 1'b0;
    end else begin
      slip_prev_q <= slip_s;
      if (!manual_align) begin
        slip_q <= '0; // count meaningful only in manual alignment
      end else if (slip_step) begin
        slip_q <= slip_next; // [R3]
      end
    end
  end

  // status outputs, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked_to_data_o     <= 1'b0;
      sig_detect_o         <= 1'b0;
      elec_idle_o          <= 1'b0;
      fifo_error_o         <= 1'b0;
      aligner_slip_count_o <= '0;
    end else begin
      locked_to_data_o     <= locked_data; // [R4]
      sig_detect_o         <= sigdet_d;    // [R9]
      elec_idle_o          <= eidle_d;     // [R11]
      fifo_error_o         <= fifo_err_d;  // [R1]
      aligner_slip_count_o <= slip_next_or_hold(slip_q);
    end
  end

  // keeps the reported value in range even if the counter were corrupted
  function automatic logic [SLIP_W-1:0] slip_next_or_hold(input logic [SLIP_W-1:0] v);
    slip_next_or_hold = (v > SLIP_LAST) ? SLIP_LAST : v; // [R3]
  endfunction

  // clock dividers; outputs toggle on enable so they come from flops
  // dividers run free, so an enabled clock starts within one half period
  wire                rd_tick      = (rd_div_q == RDCLK_HALF);
  wire                rec_tick     = (rec_div_q == RECCLK_HALF);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_div_q        <= '0;
      rec_div_q       <= '0;
      fifo_read_clk_o <= 1'b0;
      recov_clk_o     <= 1'b0;
    end else begin
      rd_div_q  <= rd_tick ? '0 : rd_div_q + 1'b1;
      rec_div_q <= rec_tick ? '0 : rec_div_q + 1'b1;
      if (!rdclk_en) begin
        fifo_read_clk_o <= 1'b0; // [R2]
      end else if (rd_tick) begin
        fifo_read_clk_o <= ~fifo_read_clk_o; // [R2]
      end
      if (!gigabit_ethernet_mode || !locked_data) begin
        recov_clk_o <= 1'b0; // [R10]
      end else if (rec_tick) begin
        recov_clk_o <= ~recov_clk_o; // [R10]
      end
    end
  end

  // interrupt events: lock change, fifo error rise, detect rise
  // lock counts both ways so software also hears of a lost lock
  wire [IRQ_W-1:0]    irq_evt;
  assign irq_evt[IRQ_LOCK_BIT]   = locked_data ^ locked_to_data_o;
  assign irq_evt[IRQ_FIFO_BIT]   = fifo_err_d & ~fifo_error_o;
  assign irq_evt[IRQ_SIGDET_BIT] = sigdet_d & ~sig_detect_o;

  // read clears, a same-cycle event survives the clear
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (rd_istat) begin
      irq_stat_d = '0;
    end
    irq_stat_d = irq_stat_d | irq_evt;
  end

  // software registers and interrupt line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q     <= CTRL_RESET;
      thresh_q   <= THRESH_RESET;
      irq_mask_q <= '0;
      irq_stat_q <= '0;
      irq_o      <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wb_dat_i[CTRL_W-1:0];
      end
      if (wr_thresh) begin
        thresh_q <= wb_dat_i[AMP_W-1:0];
      end
      if (wr_mask) begin
        irq_mask_q <= wb_dat_i[IRQ_W-1:0];
      end
      irq_stat_q <= irq_stat_d;
      irq_o      <= |(irq_stat_d & irq_mask_q);
    end
  end

  // read mux; unmapped addresses answer zero
  // status flag and slip fields show the output flops, so a read agrees with the pins; the mode field shows cdr_q
  logic [DATA_W-1:0]  rd_data;
  always_comb begin
    rd_data = '0;
    case (wb_adr_i)
      REG_CTRL:     rd_data[CTRL_W-1:0] = ctrl_q;
      REG_THRESH:   rd_data[AMP_W-1:0]  = thresh_q;
      REG_SLIP:     rd_data[SLIP_W-1:0] = aligner_slip_count_o;
      REG_STATUS: begin
        rd_data[ST_LOCK_BIT]                = locked_to_data_o;
        rd_data[ST_SIGDET_BIT]              = sig_detect_o;
        rd_data[ST_FIFOERR_BIT]             = fifo_error_o;
        rd_data[ST_EIDLE_BIT]               = elec_idle_o;
        rd_data[ST_MODE_LSB +: 2]           = cdr_q;
        rd_data[ST_SLIP_LSB +: SLIP_W]      = aligner_slip_count_o;
      end
      REG_IRQ_STAT: rd_data[IRQ_W-1:0]  = irq_stat_q;
      REG_IRQ_MASK: rd_data[IRQ_W-1:0]  = irq_mask_q;
      default:      rd_data = '0;
    endcase
  end

  // single-wait-state acknowledge for every address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : '0;
    end
  end
endmodule
`default_nettype wire

// File: sim/rcs_fabric_model.sv
/*
  Fabric model: classic Wishbone master with one transfer task.
  Assumes a slave that answers within 20 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module rcs_fabric_model (
  // clock
  input  wire logic                       clk_i,
  // request
  output logic                            cyc_o,
  output logic                            stb_o,
  output logic                            we_o,
  output logic      [rcs_pkg::ADDR_W-1:0] adr_o,
  output logic      [3:0]                 sel_o,
  output logic      [rcs_pkg::DATA_W-1:0] dat_o,
  // answer and wait limit
  input  wire logic                       ack_i,
  input  wire logic [rcs_pkg::DATA_W-1:0] dat_i,
  output logic                            tmo_o
);
  import rcs_pkg::*;
  initial begin
    {cyc_o, stb_o, we_o, tmo_o} = 4'h0;
    adr_o = '0;
    sel_o = 4'h0;
    dat_o = '0;
  end
  // request held until ack is seen; data flipped on release so nothing stale looks valid
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r);
    int n;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o} <= {2'b11, w};
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    r = dat_i;
    tmo_o <= (ack_i !== 1'b1);
    {cyc_o, stb_o} <= 2'b00;
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// File: sim/rcs_top_asserts.sv
/*
  Checker bound to rcs_top: lock forcing, fifo flag, slip count, bus.
  Assumes one clock and the top's synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rcs_top_asserts (
  // clock and reset
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  // bus handshake
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_ack_o,
  // lock, fifo and aligner
  input wire logic                       lock_to_data_i,
  input wire logic                       lock_to_ref_i,
  input wire logic                       locked_to_data_o,
  input wire logic [rcs_pkg::LVL_W-1:0]  fifo_level_i,
  input wire logic                       fifo_error_o,
  input wire logic [rcs_pkg::SLIP_W-1:0] aligner_slip_count_o,
  input wire logic                       fifo_read_clk_o
);
  import rcs_pkg::*;
  // full and empty both count as an error
  wire logic lvl_bad = (fifo_level_i >= FIFO_FULL_LVL) || (fifo_level_i == FIFO_EMPTY_LVL);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // pins pass two sync flops and an output flop, so four samples suffice
  chk_fifo_flag: assert property (!$past(rst_i) |-> fifo_error_o == $past(lvl_bad))
    else $error("fifo error flag wrong");
  chk_slip_range: assert property (aligner_slip_count_o <= SLIP_LAST)
    else $error("slip count above nine");
  chk_slip_step: assert property ($changed(aligner_slip_count_o) |->
    aligner_slip_count_o == 0 || aligner_slip_count_o == $past(aligner_slip_count_o) + 1)
    else $error("slip count jumped");
  chk_data_force: assert property (lock_to_data_i [*4] |-> locked_to_data_o)
    else $error("lock to data not forced");
  chk_ref_force: assert property ((!lock_to_data_i && lock_to_ref_i) [*4] |-> !locked_to_data_o)
    else $error("lock to reference not held");
  chk_rdclk_low: assert property ($fell(fifo_read_clk_o) |=> !fifo_read_clk_o)
    else $error("read clock low phase short");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_ack_reply: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  cover property ($rose(locked_to_data_o));
  cover property (aligner_slip_count_o == SLIP_LAST);
  cover property ($rose(fifo_read_clk_o));
endmodule
`default_nettype wire

// File: sim/test_rcs_top.sv
/*
  Bench for rcs_top: lock codes, fifo flag, detect, idle, slip, clocks, irq.
  Assumes the fabric model as bus master and the checker bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module test_rcs_top;
  import rcs_pkg::*;
  // clock, reset and bus
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, tmo;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [DATA_W-1:0] wb_dat_i, wb_dat_o;
  // line pins, quiet at start
  logic              lock_to_data_i = 1'b0, lock_to_ref_i = 1'b0, freq_ok_i = 1'b0;
  logic              eidle_inferred_i = 1'b0, slip_req_i = 1'b0;
  logic [AMP_W-1:0]  line_amp_i = 8'h00;
  logic [LVL_W-1:0]  fifo_level_i = 8'h04;
  logic              locked_to_data_o, sig_detect_o, elec_idle_o, fifo_error_o;
  logic              fifo_read_clk_o, recov_clk_o;
  logic [SLIP_W-1:0] aligner_slip_count_o;
  int                error_cnt = 0;
  int                num_checks = 0;
  always #2.5 clk_i = ~clk_i;
  rcs_top dut (.*);
  rcs_fabric_model fab (.clk_i, .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i),
    .sel_o(wb_sel_i), .dat_o(wb_dat_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .tmo_o(tmo));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    fab.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    fab.xfer(1'b0, a, '0, v);
  endtask
  // rising edges of both output clocks over 32 cycles, exact whole periods
  task automatic rises(output int nr, output int nc);
    logic pr, pc;
    {nr, nc} = '0;
    {pr, pc} = {recov_clk_o, fifo_read_clk_o};
    repeat (32) begin
      @(posedge clk_i);
      nr += int'(recov_clk_o & ~pr);
      nc += int'(fifo_read_clk_o & ~pc);
      {pr, pc} = {recov_clk_o, fifo_read_clk_o};
    end
  endtask
  // a bus wait that ran out ends the run
  always @(posedge tmo) begin
    error_cnt++;
    give_verdict();
  end
  initial begin
    int m, a, thr, lv, exp, nr, nc;
    logic [DATA_W-1:0] v;
    a = $urandom(32'h4bcb_ddd1);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place ignores writes
    rd(REG_CTRL, v);
    chk(v, CTRL_RESET);
    rd(REG_THRESH, v);
    chk(v, THRESH_RESET);
    wr(8'h1C, 32'hffff_ffff);
    rd(8'h1C, v);
    chk(v, 0);
    // forced codes 01, 10, 11, then automatic 00
    for (m = 1; m < 4; m++) begin
      {lock_to_data_i, lock_to_ref_i} <= m[1:0];
      cyc(4);
      chk(locked_to_data_o, m[1]);
      rd(REG_STATUS, v);
      chk(v[5:4], m[1] ? 3 : 2);
    end
    {lock_to_data_i, lock_to_ref_i, freq_ok_i} <= 3'b001;
    cyc(4);
    chk(locked_to_data_o, 0);
    cyc(LOCK_HOLD_CYC - 10);
    chk(locked_to_data_o, 0);
    cyc(15);
    chk(locked_to_data_o, 1);
    // every level from empty past full, then random ones
    for (a = 0; a < 24; a++) begin
      lv = a < 12 ? a : $urandom % 256;
      fifo_level_i <= lv[7:0];
      cyc(2);
      chk(fifo_error_o, lv >= 8 || lv == 0);
    end
    thr = 8 + $urandom % 200;
    wr(REG_THRESH, thr);
    // mode, amplitude at or just above threshold, idle inference
    for (m = 0; m < 16; m++) begin
      line_amp_i <= AMP_W'(m[2] ? thr + 1 : thr);
      eidle_inferred_i <= 1'($urandom);
      wr(REG_CTRL, 32'(m[3]) << CTRL_INFER_BIT | 32'(m[1:0]));
      cyc(4);
      lv = (m[1:0] == 1 || m[1:0] == 2) && m[2];
      chk(sig_detect_o, lv);
      chk(elec_idle_o, m[1:0] != 2 ? 0 : m[3] ? eidle_inferred_i : !lv[0]);
    end
    lock_to_data_i <= 1'b1;
    for (m = 0; m < 4; m++) begin
      wr(REG_CTRL, 32'(m) | 32'(m[0]) << CTRL_RDCLK_BIT);
      cyc(4);
      rises(nr, nc);
      chk(nr, m == 3 ? 4 : 0);
      chk(nc, m[0] ? 8 : 0);
    end
    // slips by pin edge and by register write, wrapping after nine
    wr(REG_CTRL, 32'(1) << CTRL_MANUAL_BIT);
    exp = 0;
    for (a = 0; a < 12; a++) begin
      if (a[0]) begin
        slip_req_i <= 1'b1;
        cyc(3);
        slip_req_i <= 1'b0;
      end else begin
        wr(REG_SLIP, $urandom);
      end
      exp = (exp + 1) % 10;
      cyc(6);
      chk(aligner_slip_count_o, exp);
      rd(REG_SLIP, v);
      chk(v, exp);
    end
    wr(REG_CTRL, 0);
    cyc(3);
    chk(aligner_slip_count_o, 0);
    // fifo error rise with the bit unmasked, then masked; status stays sticky
    for (m = 1; m >= 0; m--) begin
      wr(REG_IRQ_MASK, 32'(m) << IRQ_FIFO_BIT);
      fifo_level_i <= 8'h04;
      cyc(4);
      rd(REG_IRQ_STAT, v);
      cyc(2);
      chk(irq_o, 0);
      fifo_level_i <= 8'h00;
      cyc(4);
      chk(irq_o, m);
      rd(REG_IRQ_STAT, v);
      chk(v[IRQ_FIFO_BIT], 1);
      rd(REG_IRQ_STAT, v);
      chk(v[IRQ_FIFO_BIT], 0);
      cyc(2);
      chk(irq_o, 0);
    end
    give_verdict();
  end
endmodule
bind rcs_top rcs_top_asserts chk_i (.*);
`default_nettype wire
